//--- logic/prs_slave.sv
// Two-wire slave with paged 8-bit register bank
//
// Function
// - Acknowledge address 0011000, plus general call 0000000 when enabled
// - Slave only, never drives clock
// - Lines only pulled low or released
// - Data changes while clock low only
// - Falling data, clock high: START
// - Rising data, clock high: STOP, idle
// - Master sends address plus direction
// - Eight-bit bytes, each with acknowledge
// - Acknowledge received bytes by pulling low
// - Drive data only during reads
// - High at acknowledge means not-acknowledge
// - START while active restarts addressing
// - General call enabled by bit five
// - Write bursts increment register address
// - Acked read continues at next register
// - Writable registers read back
// - Pages of up to 128 registers
// - Register 0 selects page, reset page 0
// - Host avoids reserved pages and bits
// - Page register full eight bits
// - Register 1 bit 0 self-clearing reset
// - D7 is MSB, D0 LSB
`timescale 1ns/1ps
`default_nettype none
module prs_slave
    import prs_pkg::*;
#(
    parameter int NUM_REGS = PRS_REGS_PER_PAGE,
    parameter int NUM_PAGES = 2
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // Link
    prs_link_if.slave LINK,
    // User side: page 0 register 34 and reset pulse
    output logic O_GCALL_EN,
    output logic [7:0] O_PAGE,
    output logic O_SOFT_RST
);
    // ****************************************************
    // Line conditioning
    // ****************************************************
    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK,
                  ST_RDATA, ST_RACK, ST_SKIP} prs_sstate_t;
    logic [1:0] scl_sync_q, sda_sync_q;
    logic [PRS_FILT_LEN-1:0] scl_hist_q, sda_hist_q;
    logic scl_q, sda_q, scl_prev_q, sda_prev_q;
    // Two flops, then a majority-free agreement filter
    always_ff @(posedge I_SYS_CLK) begin
        scl_sync_q <= {scl_sync_q[0], LINK.scl};
        sda_sync_q <= {sda_sync_q[0], LINK.sda};
        scl_hist_q <= {scl_hist_q[PRS_FILT_LEN-2:0], scl_sync_q[1]};
        sda_hist_q <= {sda_hist_q[PRS_FILT_LEN-2:0], sda_sync_q[1]};
        if (I_RST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            // Glitch shorter than the filter never reaches the FSM
            if (&scl_hist_q) scl_q <= 1'b1;
            else if (~|scl_hist_q) scl_q <= 1'b0;
            if (&sda_hist_q) sda_q <= 1'b1;
            else if (~|sda_hist_q) sda_q <= 1'b0;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end
    wire scl_rise = scl_q & ~scl_prev_q;
    wire scl_fall = ~scl_q & scl_prev_q;
    wire start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    wire stop_det = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
    // ****************************************************
    // Register bank
    // ****************************************************
    logic [7:0] regs_q [NUM_PAGES][NUM_REGS];
    logic [7:0] page_q;
    logic [6:0] ptr_q;
    logic ptr_valid_q;
    logic soft_rst_q;
    prs_sstate_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic rw_q, sda_low_q;
    // Page 0 and 1 are backed; others read zero except register 0, which reads the page
    wire page_ok = page_q < 8'(NUM_PAGES);
    wire [0:0] page_idx = page_q[0];
    wire [7:0] rd_byte = (ptr_q == PRS_REG_PAGE) ? page_q :
                         (ptr_q == PRS_REG_SWRST) ? PRS_REG_RST :
                         page_ok ? regs_q[page_idx][ptr_q] : PRS_REG_RST;
    wire addr_hit = (shift_q[7:1] == PRS_SLAVE_ADDR) |
                    (O_GCALL_EN & shift_q[7:1] == PRS_GCALL_ADDR &
                     ~shift_q[0]);
    wire byte_done = scl_fall & (bit_q == PRS_LAST_BIT);
    wire wr_strobe = (state_q == ST_WDATA) & byte_done & ptr_valid_q;
    // Bank store, including self-clearing reset of every register in every backed page
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST || soft_rst_q) begin
            for (int p = 0; p < NUM_PAGES; p++)
                for (int r = 0; r < NUM_REGS; r++)
                    regs_q[p][r] <= PRS_REG_RST;
        end else if (wr_strobe && page_ok &&
                     ptr_q != PRS_REG_PAGE && ptr_q != PRS_REG_SWRST) begin
            regs_q[page_idx][ptr_q] <= shift_q;
        end
    end
    assign O_GCALL_EN = regs_q[0][PRS_REG_GCALL][PRS_GCALL_BIT];
    assign O_PAGE = page_q;
    assign O_SOFT_RST = soft_rst_q;
    // ****************************************************
    // Protocol engine
    // ****************************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            sda_low_q <= 1'b0;
            page_q <= PRS_PAGE_RST;
            ptr_q <= 7'h00;
            ptr_valid_q <= 1'b0;
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= 1'b0;
            if (soft_rst_q) page_q <= PRS_PAGE_RST;
            if (start_det) begin
                // Repeated START simply re-enters addressing
                state_q <= ST_ADDR;
                bit_q <= '1; // Clock fall that ends START is no bit
                sda_low_q <= 1'b0;
                ptr_valid_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= ST_IDLE;
                sda_low_q <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE, ST_SKIP: ;
                    ST_ADDR, ST_WDATA: begin
                        // Sample on clock high, byte ends on fall
                        if (scl_rise) shift_q <= {shift_q[6:0], sda_q};
                        if (scl_fall) bit_q <= bit_q + 4'h1;
                        if (byte_done) begin
                            bit_q <= 4'h0;
                            if (state_q == ST_ADDR) begin
                                rw_q <= shift_q[0];
                                state_q <= addr_hit ? ST_AACK : ST_SKIP;
                                sda_low_q <= addr_hit;
                            end else begin
                                state_q <= ST_WACK;
                                sda_low_q <= 1'b1;
                                if (!ptr_valid_q) begin
                                    ptr_q <= shift_q[6:0];
                                    ptr_valid_q <= 1'b1;
                                end else begin
                                    if (ptr_q == PRS_REG_PAGE)
                                        page_q <= shift_q;
                                    if (ptr_q == PRS_REG_SWRST)
                                        soft_rst_q <=
                                            shift_q[PRS_SWRST_BIT];
                                    ptr_q <= ptr_q + 7'h1;
                                end
                            end
                        end
                    end
                    ST_AACK, ST_WACK: if (scl_fall) begin
                        // Release after ack clock; reads load first bit
                        if (state_q == ST_AACK && rw_q) begin
                            state_q <= ST_RDATA;
                            shift_q <= rd_byte;
                            sda_low_q <= ~rd_byte[7];
                        end else begin
                            state_q <= ST_WDATA;
                            sda_low_q <= 1'b0;
                        end
                    end
                    ST_RDATA: if (scl_fall) begin
                        // Shift MSB first on each clock low
                        bit_q <= bit_q + 4'h1;
                        shift_q <= {shift_q[6:0], 1'b1};
                        sda_low_q <= ~shift_q[6];
                        if (bit_q == PRS_LAST_BIT) begin
                            bit_q <= 4'h0;
                            state_q <= ST_RACK;
                            sda_low_q <= 1'b0;
                            ptr_q <= ptr_q + 7'h1;
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) rw_q <= ~sda_q;
                        if (scl_fall) begin
                            state_q <= rw_q ? ST_RDATA : ST_SKIP;
                            shift_q <= rd_byte;
                            sda_low_q <= rw_q & ~rd_byte[7];
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
    // ****************************************************
    // Pins
    // ****************************************************
    // Pull low or release only; clock never driven
    assign LINK.sda_o_s = 1'b0;
    assign LINK.sda_oe_n_s = ~sda_low_q;
    assign LINK.scl_oe_n_s = 1'b1;
endmodule
`default_nettype wire

//--- logic/prs_pkg.sv
// Shared constants for the paged-register two-wire slave and its master
package prs_pkg;
    // ****************************************************
    // Bus addressing
    // ****************************************************
    localparam logic [6:0] PRS_SLAVE_ADDR = 7'h18;
    localparam logic [6:0] PRS_GCALL_ADDR = 7'h00;
    localparam int PRS_BITS_PER_BYTE = 8;
    localparam logic [3:0] PRS_LAST_BIT = 4'h7;
    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [6:0] PRS_REG_PAGE = 7'h00;
    localparam logic [6:0] PRS_REG_SWRST = 7'h01;
    localparam logic [6:0] PRS_REG_GCALL = 7'h22;
    localparam int PRS_GCALL_BIT = 5;
    localparam int PRS_SWRST_BIT = 0;
    localparam logic [7:0] PRS_PAGE_RST = 8'h00;
    localparam logic [7:0] PRS_REG_RST = 8'h00;
    localparam int PRS_REGS_PER_PAGE = 128;
    // ****************************************************
    // Master command port (Avalon-MM, word offsets as bytes)
    // ****************************************************
    localparam logic [3:0] PRS_CSR_ADDR = 4'h0;
    localparam logic [3:0] PRS_CSR_DATA = 4'h4;
    localparam logic [3:0] PRS_CSR_CTRL = 4'h8;
    localparam logic [3:0] PRS_CSR_STAT = 4'hc;
    localparam int PRS_CTRL_GO = 0;
    localparam int PRS_CTRL_READ = 1;
    localparam int PRS_CTRL_STOP = 2;
    localparam int PRS_CTRL_START = 3;
    // ****************************************************
    // Timing
    // ****************************************************
    localparam int PRS_CLK_MHZ = 125;
    localparam int PRS_SCL_HALF_NS = 2500;
    localparam int PRS_SCL_HALF_CYC = PRS_SCL_HALF_NS * PRS_CLK_MHZ / 1000;
    localparam int PRS_FILT_LEN = 3;
endpackage

//--- logic/prs_link_if.sv
// Open-drain two-wire link joining the slave and the master
`timescale 1ns/1ps
`default_nettype none
interface prs_link_if;
    logic scl_oe_n_m;
    logic sda_o_m;
    logic sda_oe_n_m;
    logic sda_oe_n_s;
    logic sda_o_s;
    logic scl_oe_n_s;
    wire logic scl;
    wire logic sda;
    // Wired-AND of both parties with pull-up
    assign scl = scl_oe_n_m & scl_oe_n_s;
    assign sda = (sda_oe_n_m | sda_o_m) & (sda_oe_n_s | sda_o_s);
    modport slave (input scl, sda, output sda_o_s, sda_oe_n_s, scl_oe_n_s);
    modport master (input scl, sda, output scl_oe_n_m, sda_o_m, sda_oe_n_m);
endinterface
`default_nettype wire

//--- logic/prs_master.sv
// Two-wire bus master with Avalon-MM command registers
`timescale 1ns/1ps
`default_nettype none
module prs_master
    import prs_pkg::*;
#(
    parameter int HALF_CYC = PRS_SCL_HALF_CYC
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // Avalon-MM slave
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // Link
    prs_link_if.master LINK
);
    typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} prs_mstate_t;
    // ****************************************************
    // Command registers
    // ****************************************************
    prs_mstate_t state_q;
    logic [7:0] tx_q, rx_q;
    logic do_read_q, do_stop_q, do_start_q, busy_q, nack_q, rd_ack_q;
    logic [15:0] cnt_q;
    logic [3:0] bit_q;
    logic [1:0] phase_q;
    logic scl_low_q, sda_low_q;
    logic [1:0] scl_s_q, sda_s_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    wire go = I_AVS_WRITE & (I_AVS_ADDRESS == PRS_CSR_CTRL) &
              I_AVS_WRITEDATA[PRS_CTRL_GO] & ~busy_q;
    // Reads answer one cycle after the request
    assign O_AVS_WAITREQUEST = I_AVS_READ & ~rvalid_q;
    assign O_AVS_READDATA = rdata_q;
    wire [31:0] rd_mux = (I_AVS_ADDRESS == PRS_CSR_DATA) ? {24'h0, rx_q} :
                         (I_AVS_ADDRESS == PRS_CSR_ADDR) ? {24'h0, tx_q} :
                         (I_AVS_ADDRESS == PRS_CSR_STAT) ?
                         {30'h0, nack_q, busy_q} : 32'h0;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rdata_q <= 32'h0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= I_AVS_READ & ~rvalid_q;
            rdata_q <= rd_mux;
        end
    end
    // ****************************************************
    // Bit engine
    // ****************************************************
    wire tick = (cnt_q == 16'(HALF_CYC - 1));
    always_ff @(posedge I_SYS_CLK) begin
        scl_s_q <= {scl_s_q[0], LINK.scl};
        sda_s_q <= {sda_s_q[0], LINK.sda};
        if (I_RST) begin
            state_q <= MS_IDLE;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            {do_read_q, do_stop_q, do_start_q} <= 3'b000;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            rd_ack_q <= 1'b0;
            cnt_q <= 16'h0;
            bit_q <= 4'h0;
            phase_q <= 2'h0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            cnt_q <= (tick || state_q == MS_IDLE) ? 16'h0 : cnt_q + 16'h1;
            if (I_AVS_WRITE && I_AVS_ADDRESS == PRS_CSR_ADDR && !busy_q)
                tx_q <= I_AVS_WRITEDATA[7:0];
            if (I_AVS_WRITE && I_AVS_ADDRESS == PRS_CSR_DATA && !busy_q)
                rd_ack_q <= I_AVS_WRITEDATA[8];
            unique case (state_q)
                MS_IDLE: if (go) begin
                    busy_q <= 1'b1;
                    do_read_q <= I_AVS_WRITEDATA[PRS_CTRL_READ];
                    do_stop_q <= I_AVS_WRITEDATA[PRS_CTRL_STOP];
                    do_start_q <= I_AVS_WRITEDATA[PRS_CTRL_START];
                    state_q <= I_AVS_WRITEDATA[PRS_CTRL_START] ?
                               MS_START : MS_BIT;
                    phase_q <= 2'h0;
                    bit_q <= 4'h0;
                end
                MS_START: if (tick) begin
                    // Release, raise clock, pull data, pull clock
                    phase_q <= phase_q + 2'h1;
                    unique case (phase_q)
                        2'h0: sda_low_q <= 1'b0;
                        2'h1: scl_low_q <= 1'b0;
                        2'h2: sda_low_q <= 1'b1;
                        default: begin
                            scl_low_q <= 1'b1;
                            state_q <= MS_BIT;
                        end
                    endcase
                end
                MS_BIT: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    unique case (phase_q)
                        2'h0: sda_low_q <= (bit_q == 4'h8) ?
                              (do_read_q & rd_ack_q) :
                              (~do_read_q & ~tx_q[3'(7 - bit_q)]);
                        2'h1: scl_low_q <= 1'b0;
                        2'h2: begin
                            if (bit_q == 4'h8) nack_q <= sda_s_q[1];
                            else rx_q <= {rx_q[6:0], sda_s_q[1]};
                        end
                        default: begin
                            scl_low_q <= 1'b1;
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                state_q <= do_stop_q ? MS_STOP : MS_IDLE;
                                busy_q <= do_stop_q;
                            end
                        end
                    endcase
                end
                MS_STOP: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    unique case (phase_q)
                        2'h0: sda_low_q <= 1'b1;
                        2'h1: scl_low_q <= 1'b0;
                        2'h2: sda_low_q <= 1'b0;
                        default: begin
                            state_q <= MS_IDLE;
                            busy_q <= 1'b0;
                        end
                    endcase
                end
            endcase
        end
    end
    // Open-drain drive: enable low pulls the line low
    assign LINK.scl_oe_n_m = ~scl_low_q;
    assign LINK.sda_o_m = 1'b0;
    assign LINK.sda_oe_n_m = ~sda_low_q;
endmodule
`default_nettype wire

//--- verification/prs_link_props.sv
// Concurrent checks on the two-wire link between slave and master
`timescale 1ns/1ps
`default_nettype none
module prs_link_props
    import prs_pkg::*;
(
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // Link drivers and resolved lines
    input wire logic scl_oe_n_m,
    input wire logic sda_o_m,
    input wire logic sda_oe_n_m,
    input wire logic sda_oe_n_s,
    input wire logic sda_o_s,
    input wire logic scl_oe_n_s,
    input wire logic scl,
    input wire logic sda
);
    // ****************************************************
    // Bit framing tracker
    // ****************************************************
    logic scl_q;
    logic sda_q;
    logic first_q;
    logic hit_q;
    logic rd_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    // Line events seen on the resolved wires
    wire logic scl_rise = scl & ~scl_q;
    wire logic start_w = scl & scl_q & sda_q & ~sda;
    wire logic stop_w = scl & scl_q & ~sda_q & sda;
    wire logic slot_w = scl_rise & (cnt_q == 4'h8);
    wire logic adr_me = (sh_q[7:1] == PRS_SLAVE_ADDR);
    wire logic rd_phase = hit_q & rd_q & ~first_q;
    // Ninth rising clock is the ack slot; a START restarts the count
    always_ff @(posedge I_SYS_CLK) begin
        scl_q <= scl;
        sda_q <= sda;
        if (I_RST) begin
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            hit_q <= 1'b0;
            rd_q <= 1'b0;
            sh_q <= 8'h00;
        end else if (start_w) begin
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            hit_q <= 1'b0;
        end else if (slot_w) begin
            cnt_q <= 4'h0;
            first_q <= 1'b0;
            if (first_q) begin
                hit_q <= adr_me;
                rd_q <= sh_q[0];
            end
        end else if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
            sh_q <= {sh_q[6:0], sda};
        end
    end
    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    sequence s_addr_slot;
        slot_w && first_q;
    endsequence
    sequence s_data_slot;
        slot_w && !first_q && hit_q;
    endsequence
    no_clk_drive_a: assert property (scl_oe_n_s)
        else $error("slave pulled the clock line");
    open_drain_a: assert property (!sda_o_s && !sda_o_m)
        else $error("data line driven high");
    slave_edge_a: assert property ($changed(sda_oe_n_s) |-> !scl)
        else $error("slave moved data while clock high");
    addr_ack_a: assert property (s_addr_slot ##0 adr_me |-> !sda_oe_n_s)
        else $error("own address not acknowledged");
    addr_ignore_a: assert property (s_addr_slot ##0
        (!adr_me && sh_q[7:1] != PRS_GCALL_ADDR) |-> sda_oe_n_s)
        else $error("foreign address acknowledged");
    data_ack_a: assert property (s_data_slot ##0 !rd_q |-> !sda_oe_n_s)
        else $error("written byte not acknowledged");
    read_release_a: assert property (s_data_slot ##0 rd_q |-> sda_oe_n_s)
        else $error("slave held data in master ack slot");
    write_quiet_a: assert property (scl_rise && cnt_q != 4'h8 &&
        !rd_phase |-> sda_oe_n_s)
        else $error("slave drove data outside a read");
    stop_idle_a: assert property (stop_w |=> sda_oe_n_s [*8])
        else $error("slave active after stop");
endmodule
`default_nettype wire

//--- verification/test_i2c_paged_register_slave.sv
// Self-checking bench: master and paged-register slave across the link
`timescale 1ns/1ps
`default_nettype none
module test_i2c_paged_register_slave import prs_pkg::*;;
    // ****************************************************
    // Setup
    // ****************************************************
    localparam int HALF = 20; // Short link half-period keeps the run small
    localparam int LIMIT = 90000;
    localparam logic [7:0] ADR_W = {PRS_SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADR_R = {PRS_SLAVE_ADDR, 1'b1};
    localparam logic [3:0] C_GO = 4'h1 << PRS_CTRL_GO;
    localparam logic [3:0] C_RD = 4'h1 << PRS_CTRL_READ;
    localparam logic [3:0] C_SP = 4'h1 << PRS_CTRL_STOP;
    localparam logic [3:0] C_ST = 4'h1 << PRS_CTRL_START;
    typedef struct packed {logic [6:0] r; logic [7:0] w; logic [7:0] e;} prs_row_t;
    // Write value and expected readback; page rows walk unbacked pages too
    prs_row_t rows [10] = '{'{7'h22, 8'h20, 8'h20}, '{7'h05, 8'ha5, 8'ha5},
        '{7'h7f, 8'h5a, 8'h5a}, '{7'h00, 8'hff, 8'hff},
        '{7'h00, 8'h0c, 8'h0c},
        '{7'h00, 8'h01, 8'h01}, '{7'h05, 8'h3c, 8'h3c}, '{7'h00, 8'h00, 8'h00},
        '{7'h05, 8'ha5, 8'ha5}, '{7'h01, 8'h00, 8'h00}};
    logic clk, rst, av_rd, av_wr, av_wait, gc_en, srst;
    logic [3:0] av_adr;
    logic [31:0] av_wd, av_rdata, st, d;
    logic [7:0] page, v;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int pulses = 0;
    int p0;
    prs_link_if i_prs_link_if();
    prs_slave i_prs_slave(.I_SYS_CLK(clk), .I_RST(rst), .LINK(i_prs_link_if),
        .O_GCALL_EN(gc_en), .O_PAGE(page), .O_SOFT_RST(srst));
    prs_master #(.HALF_CYC(HALF)) i_prs_master(.I_SYS_CLK(clk), .I_RST(rst),
        .I_AVS_ADDRESS(av_adr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
        .I_AVS_WRITEDATA(av_wd), .O_AVS_READDATA(av_rdata),
        .O_AVS_WAITREQUEST(av_wait), .LINK(i_prs_link_if));
    prs_link_props i_prs_link_props(.I_SYS_CLK(clk), .I_RST(rst),
        .scl_oe_n_m(i_prs_link_if.scl_oe_n_m), .sda_o_m(i_prs_link_if.sda_o_m),
        .sda_oe_n_m(i_prs_link_if.sda_oe_n_m),
        .sda_oe_n_s(i_prs_link_if.sda_oe_n_s), .sda_o_s(i_prs_link_if.sda_o_s),
        .scl_oe_n_s(i_prs_link_if.scl_oe_n_s), .scl(i_prs_link_if.scl),
        .sda(i_prs_link_if.sda));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard and soft reset pulse counter
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (srst === 1'b1) pulses <= pulses + 1;
        if (cyc >= LIMIT) begin
            err_total++;
            tally_and_finish();
        end
    end
    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One bus cycle; entered just after a rising edge, held until accepted
    task automatic avs(input logic rd, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat);
        av_rd <= rd;
        av_wr <= ~rd;
        av_adr <= a;
        av_wd <= wd;
        @(posedge clk);
        while (av_wait !== 1'b0) @(posedge clk);
        rdat = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk);
    endtask
    // One byte on the link, then poll busy until it is done
    task automatic byte_op(input logic [7:0] b, input logic [3:0] ctl,
                           output logic [31:0] s);
        logic [31:0] x;
        avs(1'b0, PRS_CSR_ADDR, {24'h0, b}, x);
        avs(1'b0, PRS_CSR_CTRL, {28'h0, ctl}, x);
        s = 32'h1;
        while (s[0] !== 1'b0) avs(1'b1, PRS_CSR_STAT, 32'h0, s);
    endtask
    task automatic reg_wr(input logic [6:0] r, input logic [7:0] val);
        byte_op(ADR_W, C_GO | C_ST, st);
        chk1("address ack", 1'b0, st[1]);
        byte_op({1'b0, r}, C_GO, st);
        byte_op(val, C_GO | C_SP, st);
    endtask
    task automatic reg_rd(input logic [6:0] r, output logic [7:0] val);
        byte_op(ADR_W, C_GO | C_ST, st);
        byte_op({1'b0, r}, C_GO, st);
        byte_op(ADR_R, C_GO | C_ST, st);
        avs(1'b0, PRS_CSR_DATA, 32'h0, d);
        byte_op(8'h00, C_GO | C_RD | C_SP, st);
        avs(1'b1, PRS_CSR_DATA, 32'h0, d);
        val = d[7:0];
    endtask
    function automatic logic [7:0] bval(input int k);
        return 8'h81 ^ 8'(k * 37);
    endfunction
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        rst = 1'b1;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_adr = 4'h0;
        av_wd = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk8("page at reset", PRS_PAGE_RST, page);
        chk1("gcall at reset", 1'b0, gc_en);
        chk1("soft reset idle", 1'b0, srst);
        @(posedge clk);
        foreach (rows[i]) begin
            reg_wr(rows[i].r, rows[i].w);
            reg_rd(rows[i].r, v);
            chk8("readback", rows[i].e, v);
            if (rows[i].r == PRS_REG_PAGE) chk8("page out", rows[i].e, page);
        end
        // General call only while enabled; foreign address refused
        chk1("gcall enable", 1'b1, gc_en);
        byte_op(8'h00, C_GO | C_ST | C_SP, st);
        chk1("gcall ack", 1'b0, st[1]);
        byte_op({PRS_SLAVE_ADDR ^ 7'h01, 1'b0}, C_GO | C_ST | C_SP, st);
        chk1("foreign nack", 1'b1, st[1]);
        // Burst write from a loaded pointer, then acked burst read back
        byte_op(ADR_W, C_GO | C_ST, st);
        byte_op(8'h10, C_GO, st);
        for (int k = 0; k < 3; k++) byte_op(bval(k), k == 2 ? C_GO | C_SP : C_GO, st);
        byte_op(ADR_W, C_GO | C_ST, st);
        byte_op(8'h10, C_GO, st);
        byte_op(ADR_R, C_GO | C_ST, st);
        chk1("repeated start ack", 1'b0, st[1]);
        for (int k = 0; k < 3; k++) begin
            avs(1'b0, PRS_CSR_DATA, {23'h0, k != 2, 8'h0}, d);
            byte_op(8'h00, k == 2 ? C_GO | C_RD | C_SP : C_GO | C_RD, st);
            avs(1'b1, PRS_CSR_DATA, 32'h0, d);
            chk8("burst read", bval(k), d[7:0]);
        end
        // Soft reset clears the bank and the general call enable
        p0 = pulses;
        reg_wr(PRS_REG_SWRST, 8'h01);
        chk8("soft reset pulses", 8'(p0 + 1), 8'(pulses));
        chk1("gcall cleared", 1'b0, gc_en);
        reg_rd(7'h05, v);
        chk8("reg cleared", PRS_REG_RST, v);
        reg_rd(PRS_REG_SWRST, v);
        chk8("reset bit clears", 8'h00, v);
        byte_op(8'h00, C_GO | C_ST | C_SP, st);
        chk1("gcall refused", 1'b1, st[1]);
        // Second reset mid-run returns to page 0
        reg_wr(PRS_REG_PAGE, 8'h01);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk8("page after reset", PRS_PAGE_RST, page);
        @(posedge clk);
        reg_rd(PRS_REG_PAGE, v);
        chk8("page reg after reset", PRS_PAGE_RST, v);
        tally_and_finish();
    end
endmodule
`default_nettype wire
